// ===== include/mii_tx_map.svh
// register-free constants for the mii transmit client port
// assumes inclusion by bare name from the package file; the rtl files do not include it themselves
`ifndef MII_TX_MAP_SVH
`define MII_TX_MAP_SVH
`define LANE_BYTES 8
`define DATA_W 64
`define CTRL_W 8
`define BYTE_W 8
`define CH_START 8'hfb
`define CH_TERM 8'hfd
`define CH_IDLE 8'h07
`define CH_ERROR 8'hfe
`define CH_PREAMBLE 8'h55
`define CH_SFD 8'hd5
`define MARKER_CYCLES 3'h4
`define MARKER_CNT_W 3
`define LINE_IDX_W 6
`define PCS_LATENCY_MAX 4'ha
`endif

// ===== include/mii_tx_pkg.sv
// types shared by the transmit client port and its serialiser
// assumes mii_tx_map.svh on the include path
`include "mii_tx_map.svh"
package mii_tx_pkg;
  typedef struct packed {
    logic [`CTRL_W-1:0] ctrl;
    logic [`DATA_W-1:0] data;
  } mii_word_type;
  typedef enum logic [1:0] {
    idle_st,
    run_st,
    marker_st
  } tx_state_type;
endpackage

// ===== rtl/mii_line_shift.sv
// serialiser: one mii word out on the line, bit 0 of byte 0 first
// assumes the caller loads only when busy is low
`timescale 1ns/1ps
module mii_line_shift
  import mii_tx_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic load,
  input wire mii_word_type word,
  output logic busy,
  output logic line_bit,
  output logic line_ctrl
);
  logic [`DATA_W-1:0] shreg;
  logic [`CTRL_W-1:0] creg;
  logic [`LINE_IDX_W-1:0] idx;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      shreg <= '0;
      creg <= '0;
      idx <= '0;
      busy <= 1'b0;
    end else if (ce) begin
      if (load) begin
        shreg <= word.data;
        creg <= word.ctrl;
        idx <= '0;
        busy <= 1'b1;
      end else if (busy) begin
        // lsb first: lowest byte, then bit 0 of each byte
        shreg <= {1'b0, shreg[`DATA_W-1:1]};
        idx <= idx + 6'h01;
        if (idx[2:0] == 3'h7) begin
          creg <= {1'b0, creg[`CTRL_W-1:1]};
        end
        if (idx == 6'h3f) begin
          busy <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      line_bit <= 1'b0;
      line_ctrl <= 1'b0;
    end else if (ce) begin
      line_bit <= busy & shreg[0];
      line_ctrl <= busy & creg[0];
    end
  end
endmodule

// ===== rtl/mii_tx_pcs_client_port.sv
// transmit-side mii client port of a pcs-only channel, 10g/25g width
// assumes the source keeps its own handshake, freeze and marker rules
`timescale 1ns/1ps
// Summary of operation
// - all port signals on tx clock
// - one control flag per data byte
// - flag one is control, zero is data
// - start, terminate, idle, error are control; an idle byte with its flag clear raises no protocol_error
// - lowest byte lane leaves first
// - bit zero of word leaves first
// - ready high only when pcs accepts
// - packet starts may sit anywhere
module mii_tx_pcs_client_port
  import mii_tx_pkg::*;
(
  input wire logic tx_channel_clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic pcs_able,
  input wire mii_word_type tx_word,
  input wire logic tx_valid,
  input wire logic marker_gap_request,
  output logic tx_ready,
  output logic line_bit,
  output logic line_ctrl,
  output logic protocol_error,
  output logic marker_seen
);
  tx_state_type state;
  mii_word_type held;
  logic shift_busy;
  logic load;
  logic [`MARKER_CNT_W-1:0] marker_cnt;
  logic valid_q;
  logic marker_q;
  logic take;

  function automatic logic is_ctrl_char(input logic [`BYTE_W-1:0] b);
    is_ctrl_char = (b == `CH_START) || (b == `CH_TERM) || (b == `CH_IDLE) || (b == `CH_ERROR);
  endfunction

  // a word is taken on any valid non-marker cycle, at any lane alignment
  assign take = tx_valid && !marker_gap_request;
  assign load = take && !shift_busy;

  // ready only when the pcs is able and the serialiser has room
  always_ff @(posedge tx_channel_clock) begin
    if (!nrst) begin
      tx_ready <= 1'b0;
    end else if (ce) begin
      tx_ready <= pcs_able && !shift_busy;
    end
  end

  always_ff @(posedge tx_channel_clock) begin
    if (!nrst) begin
      state <= idle_st;
    end else if (ce) begin
      case (state)
        idle_st: begin
          if (tx_valid) begin
            state <= run_st;
          end
        end
        run_st: begin
          if (tx_valid && marker_gap_request) begin
            state <= marker_st;
          end else if (!tx_valid) begin
            state <= idle_st;
          end
        end
        marker_st: begin
          if (tx_valid && !marker_gap_request) begin
            state <= run_st;
          end
        end
        default: begin
          state <= idle_st;
        end
      endcase
    end
  end

  // marker length counted in valid cycles only
  always_ff @(posedge tx_channel_clock) begin
    if (!nrst) begin
      marker_cnt <= '0;
      marker_seen <= 1'b0;
    end else if (ce) begin
      marker_seen <= 1'b0;
      if (tx_valid && marker_gap_request) begin
        marker_cnt <= marker_cnt + 3'h1;
      end else if (tx_valid) begin
        marker_seen <= marker_cnt == `MARKER_CYCLES;
        marker_cnt <= '0;
      end
    end
  end

  always_ff @(posedge tx_channel_clock) begin
    if (!nrst) begin
      held <= '0;
      valid_q <= 1'b0;
      marker_q <= 1'b0;
    end else if (ce) begin
      valid_q <= tx_valid;
      marker_q <= marker_gap_request;
      if (take) begin
        held <= tx_word;
      end
    end
  end

  // flags a non-idle control byte whose flag is clear, or a lane change right after a valid marker cycle
  always_ff @(posedge tx_channel_clock) begin
    if (!nrst) begin
      protocol_error <= 1'b0;
    end else if (ce) begin
      protocol_error <= 1'b0;
      for (int k = 0; k < `LANE_BYTES; k++) begin
        if (take && !tx_word.ctrl[k] && is_ctrl_char(tx_word.data[k*`BYTE_W +: `BYTE_W])
            && (tx_word.data[k*`BYTE_W +: `BYTE_W] != `CH_IDLE)) begin
          protocol_error <= 1'b1;
        end
      end
      if ((!valid_q || marker_q) && tx_word != held && valid_q) begin
        protocol_error <= 1'b1;
      end
    end
  end

  mii_line_shift u_shift (
    .clk(tx_channel_clock),
    .nrst(nrst),
    .ce(ce),
    .load(load),
    .word(tx_word),
    .busy(shift_busy),
    .line_bit(line_bit),
    .line_ctrl(line_ctrl)
  );

  ready_low_reset_a: assert property (@(posedge tx_channel_clock)
    !nrst |=> !tx_ready) else $error("ready high right after reset");
  ready_needs_pcs_a: assert property (@(posedge tx_channel_clock) disable iff (!nrst)
    (ce && !pcs_able) |=> !tx_ready) else $error("ready high while pcs unable");
  ready_busy_a: assert property (@(posedge tx_channel_clock) disable iff (!nrst)
    (ce && shift_busy) |=> !tx_ready) else $error("ready high while serialiser busy");
  sequence word_loaded_s;
    ce && load && tx_word.data[0];
  endsequence
  first_bit_a: assert property (@(posedge tx_channel_clock) disable iff (!nrst)
    word_loaded_s ##1 ce |=> line_bit) else $error("bit zero not sent first");
  sequence ctrl_loaded_s;
    ce && load && tx_word.ctrl[0];
  endsequence
  first_ctrl_a: assert property (@(posedge tx_channel_clock) disable iff (!nrst)
    ctrl_loaded_s ##1 ce |=> line_ctrl) else $error("lane zero flag not first");
  marker_state_a: assert property (@(posedge tx_channel_clock) disable iff (!nrst)
    (ce && state == marker_st && !tx_valid) |=> state == marker_st) else $error("marker state left while stalled");
  marker_hold_a: assert property (@(posedge tx_channel_clock) disable iff (!nrst)
    (ce && tx_valid && marker_gap_request && marker_cnt == 3'h0) |=> marker_cnt == 3'h1)
    else $error("marker count did not advance");
  held_word_a: assert property (@(posedge tx_channel_clock) disable iff (!nrst)
    (ce && take) |=> held == $past(tx_word)) else $error("accepted word not captured");
endmodule

// ===== test/mii_tx_pcs_client_port_bench.sv
// self-checking bench for the mii transmit client port
// assumes the source model and a 100 mhz tx clock
`timescale 1ns/1ps
module mii_tx_pcs_client_port_bench
  import mii_tx_pkg::*;
;
  localparam mii_word_type START_W = '{8'h01, 64'hd5555555555555fb};
  localparam mii_word_type DATA_W = '{8'h80, 64'hfd0123456789abcd};
  localparam mii_word_type BAD_W = '{8'h00, 64'h00000000000000fe};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic pcs_able = 1'b0;
  logic am_go = 1'b0;
  mii_word_type want = START_W;
  mii_word_type tx_word;
  logic tx_valid, marker_gap_request, tx_ready, line_bit, line_ctrl, protocol_error, marker_seen;
  int fails = 0;
  int checked = 0;
  always #5 clk = ~clk;
  mii_tx_source_model mii_tx_source_model_inst (.clk(clk), .nrst(nrst), .ready(tx_ready), .want(want),
    .am_go(am_go), .valid(tx_valid), .word(tx_word), .am(marker_gap_request));
  mii_tx_pcs_client_port mii_tx_pcs_client_port_inst (.tx_channel_clock(clk), .nrst(nrst), .ce(1'b1),
    .pcs_able(pcs_able), .tx_word(tx_word), .tx_valid(tx_valid), .marker_gap_request(marker_gap_request),
    .tx_ready(tx_ready), .line_bit(line_bit), .line_ctrl(line_ctrl), .protocol_error(protocol_error),
    .marker_seen(marker_seen));
  task automatic check(input string what, input logic [71:0] seen, input logic [71:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic reset_case();
    int i;
    repeat (4) @(negedge clk);
    check("ready while unable", tx_ready, 1'b0);
    pcs_able <= 1'b1;
    for (i = 0; i < 6 && tx_ready !== 1'b1; i++) @(negedge clk);
    check("ready when able", tx_ready, 1'b1);
  endtask
  // exp is the word now offered; nxt is queued during the valid tail
  task automatic send(input mii_word_type exp, input mii_word_type nxt);
    int i;
    for (i = 0; i < 200 && tx_ready !== 1'b1; i++) @(negedge clk);
    for (i = 0; i < 200 && tx_ready !== 1'b0; i++) @(negedge clk);
    want <= nxt;
    // ready is seen low one edge after the load, when bit 0 already stands
    for (i = 0; i < 64; i++) begin
      check("line bit", line_bit, exp.data[i]);
      check("line flag", line_ctrl, exp.ctrl[i/8]);
      @(negedge clk);
    end
  endtask
  task automatic error_case();
    int i;
    for (i = 0; i < 150 && protocol_error !== 1'b1; i++) @(negedge clk);
    check("unflagged control", protocol_error, 1'b1);
  endtask
  task automatic marker_case();
    int i;
    am_go <= 1'b1;
    for (i = 0; i < 400 && marker_seen !== 1'b1; i++) @(negedge clk);
    am_go <= 1'b0;
    check("marker run", marker_seen, 1'b1);
  endtask
  initial begin
    repeat (3) @(negedge clk);
    nrst <= 1'b1;
    reset_case();
    send(START_W, DATA_W);
    send(DATA_W, BAD_W);
    error_case();
    marker_case();
    give_verdict();
  end
  // whole run needs about 220 cycles
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    give_verdict();
  end
endmodule

// ===== test/mii_tx_source_model.sv
// behavioural user-logic source for the mii transmit client port
// assumes one tx clock; drives its outputs on the falling edge
`timescale 1ns/1ps
module mii_tx_source_model
  import mii_tx_pkg::*;
#(
  parameter int LAT = 3,
  // 25g rs-fec run length; 0 would mean no markers at all
  parameter int AM_RUN = 4,
  // shortened simulation period hardware would use 81916
  parameter int MARKER_INTERVAL = 5119
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ready,
  input wire mii_word_type want,
  input wire logic am_go,
  output logic valid,
  output mii_word_type word,
  output logic am
);
  logic [LAT-1:0] pipe;
  logic frozen_q;
  int run;
  int gap;
  logic armed;
  assign valid = pipe[LAT-1];
  always_ff @(negedge clk) begin
    if (!nrst) begin
      pipe <= '0;
      word <= want;
      am <= 1'b0;
      run <= 0;
      gap <= 0;
      armed <= 1'b0;
      frozen_q <= 1'b1;
    end else begin
      pipe <= {pipe[LAT-2:0], ready};
      frozen_q <= !valid || am;
      // lanes only move once a whole unfrozen cycle has passed
      if (valid && !am && !frozen_q) begin
        word <= want;
      end
      // run length counted in valid cycles, held while valid is low
      if (AM_RUN == 0) begin
        am <= 1'b0;
      end else if (valid && am) begin
        run <= (run == AM_RUN - 1) ? 0 : run + 1;
        am <= (run != AM_RUN - 1);
        armed <= 1'b1;
        gap <= 0;
      end else if (valid && (am_go || (armed && gap == MARKER_INTERVAL - 1))) begin
        // period reached or am_go: raise at once, a late marker breaks the link
        am <= 1'b1;
      end else if (valid && armed) begin
        gap <= gap + 1;
      end
    end
  end
endmodule
